// ### common/pvlan_defs.svh
// Register offsets, reset values and sizes for the forwarding-mask block
`ifndef PVLAN_DEFS_SVH
`define PVLAN_DEFS_SVH
`define NUM_PORTS        8
`define VID_W            12
`define ADDR_IDX_W       6
`define REG_CTRL         8'h00
`define REG_PVLAN_SEL    8'h04
`define REG_PVLAN_MASK   8'h08
`define REG_ISOLATE      8'h0C
`define REG_AWARE        8'h10
`define REG_VLAN_SEL     8'h14
`define REG_VLAN_MEMBER  8'h18
`define REG_VLAN_UNTAG   8'h1C
`define REG_PORT_SEL     8'h20
`define REG_PORT_PORT_DEFAULT_VLAN_ID    8'h24
`define REG_STATUS       8'h28
`define DEFAULT_VID      12'h001
`define DEFAULT_PVLAN    4'h1
`define NUM_VLANS        16
`endif

// ### common/pvlan_pkg.sv
// Types shared by the forwarding-mask block
package pvlan_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DATA = 2'b01
	} bus_state_type;
endpackage

// ### hw/private_vlan_forward_mask.sv
// Private VLAN forwarding-mask engine with AHB-Lite register slave
`timescale 1ns/1ns
`include "pvlan_defs.svh"
module private_vlan_forward_mask
	import pvlan_pkg::*;
#(
	parameter int NPORT = `NUM_PORTS,
	parameter int NVLAN = `NUM_VLANS
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 hsel_i,
	input  wire logic [31:0]          haddr_i,
	input  wire logic [1:0]           htrans_i,
	input  wire logic                 hwrite_i,
	input  wire logic [2:0]           hsize_i,
	input  wire logic [31:0]          hwdata_i,
	input  wire logic                 hready_i,
	output logic      [31:0]          hrdata_o,
	output logic                      hreadyout_o,
	output logic                      hresp_o,
	input  wire logic                 frm_valid_i,
	input  wire logic [7:0]           frm_src_port_i,
	input  wire logic                 frm_tagged_i,
	input  wire logic [`VID_W-1:0]    frm_vid_i,
	output logic                      fwd_valid_o,
	output logic [NPORT-1:0]          fwd_mask_o,
	output logic [NPORT-1:0]          fwd_strip_o,
	output logic [`VID_W-1:0]         fwd_vid_o
);
	localparam int VW = `VID_W;
	localparam int VIW = $clog2(NVLAN);

	// PVLAN storage: one source-port mask per id, id range 1..NPORT
	logic [NPORT-1:0]  pvlan_mask_ff [1:NPORT];
	logic [NPORT:1]    pvlan_valid_ff;
	logic [NPORT-1:0]  vlan_member_ff [NVLAN];
	logic [NPORT-1:0]  vlan_untag_ff [NVLAN];
	logic [VW-1:0]     port_default_vlan_id_ff [NPORT];
	logic [NPORT-1:0]  isolate_ff;
	logic [NPORT-1:0]  aware_ff;
	logic [7:0]        pvlan_sel_ff;
	logic [VIW-1:0]    vlan_sel_ff;
	logic [7:0]        port_sel_ff;
	logic              reject_ff;

	bus_state_type     state_ff;
	logic [7:0]        wr_addr_ff;
	logic              wr_pend_ff;
	logic [31:0]       hrdata_ff;
	// Fixed answers still come from flops so every output is registered
	logic              hready_ff;
	logic              hresp_ff;

	wire  bus_req   = hsel_i && hready_i && htrans_i[1];
	wire  wr_req    = bus_req && hwrite_i;
	wire  sel_ok    = (pvlan_sel_ff >= 8'h01) && (pvlan_sel_ff <= 8'(NPORT));
	wire  port_ok   = port_sel_ff < 8'(NPORT);
	wire  [7:0] ra  = haddr_i[7:0];
	wire  [NPORT-1:0] pv_rd = sel_ok ? pvlan_mask_ff[pvlan_sel_ff] : '0;
	wire  [VW-1:0] port_default_vlan_id_rd = port_ok ? port_default_vlan_id_ff[port_sel_ff[$clog2(NPORT)-1:0]] : '0;

	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		case (a)
			`REG_PVLAN_SEL:   rd_mux = {24'h0, pvlan_sel_ff};
			`REG_PVLAN_MASK:  rd_mux = 32'(pv_rd);
			`REG_ISOLATE:     rd_mux = 32'(isolate_ff);
			`REG_AWARE:       rd_mux = 32'(aware_ff);
			`REG_VLAN_SEL:    rd_mux = 32'(vlan_sel_ff);
			`REG_VLAN_MEMBER: rd_mux = 32'(vlan_member_ff[vlan_sel_ff]);
			`REG_VLAN_UNTAG:  rd_mux = 32'(vlan_untag_ff[vlan_sel_ff]);
			`REG_PORT_SEL:    rd_mux = {24'h0, port_sel_ff};
			`REG_PORT_PORT_DEFAULT_VLAN_ID:   rd_mux = 32'(port_default_vlan_id_rd);
			`REG_STATUS:      rd_mux = {31'h0, reject_ff};
			`REG_CTRL:        rd_mux = 32'(pvlan_valid_ff);
			default:          rd_mux = 32'h0000_0000;
		endcase
	endfunction

	// Bus slave: zero wait states, writes land at data phase
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff   <= ST_IDLE;
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			hrdata_ff  <= 32'h0000_0000;
			hready_ff  <= 1'b1;
			hresp_ff   <= 1'b0;
		end else begin
			hready_ff  <= 1'b1;
			hresp_ff   <= 1'b0;
			state_ff   <= bus_req ? ST_DATA : ST_IDLE;
			wr_pend_ff <= wr_req;
			wr_addr_ff <= ra;
			hrdata_ff  <= (bus_req && !hwrite_i) ? rd_mux(ra) : 32'h0000_0000;
		end
	end

	wire wr_now = wr_pend_ff;
	wire [7:0] wa = wr_addr_ff;
	wire wr_ctrl = wr_now && (wa == `REG_CTRL);
	wire ctrl_add = wr_ctrl && hwdata_i[0];
	wire ctrl_del = wr_ctrl && hwdata_i[1];

	// Configuration state
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			isolate_ff   <= '0;
			aware_ff     <= '0;
			pvlan_sel_ff <= 8'h01;
			vlan_sel_ff  <= '0;
			port_sel_ff  <= 8'h00;
			reject_ff    <= 1'b0;
		end else if (wr_now) begin
			case (wa)
				`REG_ISOLATE:   isolate_ff   <= hwdata_i[NPORT-1:0];
				`REG_AWARE:     aware_ff     <= hwdata_i[NPORT-1:0];
				`REG_PVLAN_SEL: pvlan_sel_ff <= hwdata_i[7:0];
				`REG_VLAN_SEL:  vlan_sel_ff  <= hwdata_i[VIW-1:0];
				`REG_PORT_SEL:  port_sel_ff  <= hwdata_i[7:0];
				default:        ;
			endcase
			if (wr_ctrl)
				reject_ff <= (ctrl_add || ctrl_del) && !sel_ok;
		end
	end

	// PVLAN table; out-of-range id never stored
	genvar gi;
	for (gi = 1; gi <= NPORT; gi++) begin : g_pv
		wire hit = sel_ok && (pvlan_sel_ff == 8'(gi));
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				pvlan_mask_ff[gi]  <= (gi == 1) ? '1 : '0;
				pvlan_valid_ff[gi] <= (gi == 1);
			end else if (hit && ctrl_add && !pvlan_valid_ff[gi]) begin
				pvlan_mask_ff[gi]  <= '0;
				pvlan_valid_ff[gi] <= 1'b1;
			end else if (hit && ctrl_del) begin
				pvlan_mask_ff[gi]  <= '0;
				pvlan_valid_ff[gi] <= 1'b0;
			end else if (hit && wr_now && wa == `REG_PVLAN_MASK && pvlan_valid_ff[gi]) begin
				pvlan_mask_ff[gi]  <= hwdata_i[NPORT-1:0];
			end
		end
	end

	for (gi = 0; gi < NVLAN; gi++) begin : g_vl
		wire hit = wr_now && (vlan_sel_ff == VIW'(gi));
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				vlan_member_ff[gi] <= (gi == 1) ? '1 : '0;
				vlan_untag_ff[gi]  <= (gi == 1) ? '1 : '0;
			end else begin
				if (hit && wa == `REG_VLAN_MEMBER)
					vlan_member_ff[gi] <= hwdata_i[NPORT-1:0];
				if (hit && wa == `REG_VLAN_UNTAG)
					vlan_untag_ff[gi]  <= hwdata_i[NPORT-1:0];
			end
		end
	end

	// One default VLAN per port keeps an unaware port in exactly one VLAN
	for (gi = 0; gi < NPORT; gi++) begin : g_pt
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i)
				port_default_vlan_id_ff[gi] <= `DEFAULT_VID;
			else if (wr_now && wa == `REG_PORT_PORT_DEFAULT_VLAN_ID && port_sel_ff == 8'(gi))
				port_default_vlan_id_ff[gi] <= hwdata_i[VW-1:0];
		end
	end

	// Forwarding path
	wire src_ok = frm_src_port_i < 8'(NPORT);
	wire [$clog2(NPORT)-1:0] sp = frm_src_port_i[$clog2(NPORT)-1:0];
	wire src_aware = src_ok && aware_ff[sp];
	wire [VW-1:0] src_port_default_vlan_id = src_ok ? port_default_vlan_id_ff[sp] : '0;
	// Classification: tag only counts on aware ports
	wire [VW-1:0] cls_vid = (src_aware && frm_tagged_i) ? frm_vid_i : src_port_default_vlan_id;
	wire vid_in = cls_vid < VW'(NVLAN);
	wire [NPORT-1:0] vmask = vid_in ? vlan_member_ff[cls_vid[VIW-1:0]] : '0;
	wire [NPORT-1:0] umask = vid_in ? vlan_untag_ff[cls_vid[VIW-1:0]] : '0;
	wire [NPORT-1:0] src_bit = src_ok ? (NPORT'(1) << sp) : '0;

	logic [NPORT-1:0] pv_union;
	logic             src_in_pv;
	always_comb begin
		pv_union  = '0;
		src_in_pv = 1'b0;
		for (int k = 1; k <= NPORT; k++) begin
			if (pvlan_valid_ff[k] && |(pvlan_mask_ff[k] & src_bit)) begin
				pv_union  = pv_union | pvlan_mask_ff[k];
				src_in_pv = 1'b1;
			end
		end
	end

	wire src_iso = |(isolate_ff & src_bit);
	wire fwd_ok = src_ok && |(vmask & src_bit) && src_in_pv;
	// Promiscuous source sees only VLAN mask; isolated adds PVLAN and promiscuous
	wire [NPORT-1:0] iso_mask = src_iso ? (pv_union & ~isolate_ff) : '1;
	wire [NPORT-1:0] dest = fwd_ok ? (vmask & iso_mask & ~src_bit) : '0;

	logic              fv_ff;
	logic [NPORT-1:0]  fm_ff;
	logic [NPORT-1:0]  fs_ff;
	logic [VW-1:0]     fvid_ff;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fv_ff   <= 1'b0;
			fm_ff   <= '0;
			fs_ff   <= '0;
			fvid_ff <= '0;
		end else begin
			fv_ff   <= frm_valid_i;
			fm_ff   <= frm_valid_i ? dest : '0;
			fs_ff   <= frm_valid_i ? (dest & umask) : '0;
			fvid_ff <= frm_valid_i ? cls_vid : '0;
		end
	end

	assign fwd_valid_o = fv_ff;
	assign fwd_mask_o  = fm_ff;
	assign fwd_strip_o = fs_ff;
	assign fwd_vid_o   = fvid_ff;
	assign hrdata_o    = hrdata_ff;
	assign hreadyout_o = hready_ff;
	assign hresp_o     = hresp_ff;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	no_self_fwd_a: assert property (fwd_valid_o |-> (fwd_mask_o & $past(src_bit)) == '0)
		else $error("ingress port in destination mask");
	strip_subset_a: assert property ((fwd_strip_o & ~fwd_mask_o) == '0)
		else $error("strip bit outside destination");
	iso_to_iso_a: assert property (frm_valid_i && src_iso |=> (fwd_mask_o & $past(isolate_ff)) == '0)
		else $error("isolated reached isolated");
	member_only_a: assert property (frm_valid_i |=> (fwd_mask_o & ~$past(vmask)) == '0)
		else $error("non-member received frame");
	need_pv_a: assert property (frm_valid_i && !src_in_pv |=> fwd_mask_o == '0)
		else $error("forward without private vlan");
	unaware_vid_a: assert property (frm_valid_i && !src_aware |=> fwd_vid_o == $past(src_port_default_vlan_id))
		else $error("unaware port not classified to default");
	promisc_a: assert property (frm_valid_i && fwd_ok && !src_iso
		|=> fwd_mask_o == ($past(vmask) & ~$past(src_bit)))
		else $error("promiscuous mask wrong");
	reject_a: assert property (ctrl_add && !sel_ok |=> reject_ff && $stable(pvlan_valid_ff))
		else $error("bad pvlan id stored");
	new_empty_a: assert property (ctrl_add && sel_ok && !pvlan_valid_ff[pvlan_sel_ff]
		|=> pvlan_mask_ff[$past(pvlan_sel_ff)] == '0)
		else $error("new pvlan not empty");
	iso_pv_a: assert property (frm_valid_i && src_iso |=> (fwd_mask_o & ~$past(pv_union)) == '0)
		else $error("isolated escaped private vlan");

	// Lookup handshake: one request in, one answer a cycle later
	sequence lookup_s;
		frm_valid_i;
	endsequence
	sequence answer_s;
		fwd_valid_o;
	endsequence
	sequence idle_s;
		!frm_valid_i;
	endsequence
	fwd_latency_a: assert property (lookup_s |=> answer_s)
		else $error("lookup answer missing");
	fwd_pulse_a: assert property (idle_s |=> !fwd_valid_o)
		else $error("answer without lookup");
	fwd_idle_a: assert property (!fwd_valid_o |-> fwd_mask_o == '0 && fwd_strip_o == '0)
		else $error("destination while idle");
	vid_idle_a: assert property (!fwd_valid_o |-> fwd_vid_o == '0)
		else $error("vlan shown while idle");
	bad_src_a: assert property (frm_valid_i && !src_ok |=> fwd_mask_o == '0)
		else $error("unknown ingress forwarded");
	src_member_a: assert property (frm_valid_i && (vmask & src_bit) == '0
		|=> fwd_mask_o == '0)
		else $error("non-member source forwarded");

	// Classification follows the tag only on aware ports
	tag_vid_a: assert property (frm_valid_i && src_aware && frm_tagged_i
		|=> fwd_vid_o == $past(frm_vid_i))
		else $error("tagged frame not on tag vlan");
	untag_vid_a: assert property (frm_valid_i && !frm_tagged_i
		|=> fwd_vid_o == $past(src_port_default_vlan_id))
		else $error("untagged frame not on default vlan");

	// Egress tagging is decided by the untagged set alone
	keep_tag_a: assert property (fwd_valid_o
		|-> (fwd_mask_o & ~fwd_strip_o) == (fwd_mask_o & ~$past(umask)))
		else $error("tagged member lost its tag");
	strip_kept_a: assert property (frm_valid_i && !src_aware && frm_tagged_i
		|=> fwd_strip_o == (fwd_mask_o & $past(umask)))
		else $error("unaware port changed tag handling");

	// Isolation register is one flat bit per port
	iso_write_a: assert property (wr_now && wa == `REG_ISOLATE
		|=> isolate_ff == $past(hwdata_i[NPORT-1:0]))
		else $error("isolation write lost");
	iso_hold_a: assert property (!(wr_now && wa == `REG_ISOLATE) |=> $stable(isolate_ff))
		else $error("isolation changed without write");
	port_default_vlan_id_write_a: assert property (wr_now && wa == `REG_PORT_PORT_DEFAULT_VLAN_ID && port_ok
		|=> port_default_vlan_id_rd == $past(hwdata_i[VW-1:0]))
		else $error("default vlan write lost");
	vlan_write_a: assert property (wr_now && wa == `REG_VLAN_MEMBER
		|=> vlan_member_ff[$past(vlan_sel_ff)] == $past(hwdata_i[NPORT-1:0]))
		else $error("vlan member write lost");
	pv_indep_a: assert property (wr_now && wa == `REG_VLAN_MEMBER |=> $stable(pv_rd))
		else $error("vlan write touched private vlan");

	// Private VLAN table bookkeeping
	add_ok_a: assert property (ctrl_add && sel_ok
		|=> !reject_ff && pvlan_valid_ff[$past(pvlan_sel_ff)])
		else $error("valid pvlan id refused");
	reject_clear_a: assert property (wr_ctrl && sel_ok |=> !reject_ff)
		else $error("reject flag stuck");
	del_clear_a: assert property (ctrl_del && sel_ok && !ctrl_add
		|=> !pvlan_valid_ff[$past(pvlan_sel_ff)])
		else $error("pvlan entry not deleted");
	mask_gate_a: assert property (wr_now && wa == `REG_PVLAN_MASK && !sel_ok
		|=> $stable(pvlan_valid_ff))
		else $error("bad pvlan id changed table");

	// Bus slave never stalls and never errors
	bus_ok_a: assert property (hreadyout_o && !hresp_o)
		else $error("bus slave stalled or erred");
	wr_rdata_a: assert property (wr_req |=> hrdata_o == 32'h0000_0000)
		else $error("read data during write");
endmodule // private_vlan_forward_mask

// ### tb/frame_port_model.sv
// Ingress classifier and egress queue stand-in for frame lookups
`timescale 1ns/1ns
module frame_port_model (
	input  wire logic        clk_i,
	output logic             frm_valid_o,
	output logic [7:0]       frm_src_port_o,
	output logic             frm_tagged_o,
	output logic [11:0]      frm_vid_o,
	input  wire logic        fwd_valid_i,
	input  wire logic [7:0]  fwd_mask_i,
	input  wire logic [7:0]  fwd_strip_i,
	input  wire logic [11:0] fwd_vid_i
);
	initial begin
		frm_valid_o = 1'b0;
		frm_src_port_o = 8'h00;
		frm_tagged_o = 1'b0;
		frm_vid_o = 12'h000;
	end
	task automatic send(input logic [7:0] p, input logic t, input logic [11:0] v,
		output logic ok, output logic [7:0] m, output logic [7:0] s, output logic [11:0] vo);
		@(posedge clk_i);
		frm_valid_o <= 1'b1;
		frm_src_port_o <= p;
		frm_tagged_o <= t;
		frm_vid_o <= v;
		@(posedge clk_i);
		frm_valid_o <= 1'b0;
		// Released fields turn to junk so no stale value can help
		frm_src_port_o <= ~p;
		frm_tagged_o <= ~t;
		frm_vid_o <= ~v;
		@(posedge clk_i);
		ok = fwd_valid_i;
		m = fwd_mask_i;
		s = fwd_strip_i;
		vo = fwd_vid_i;
	endtask
endmodule // frame_port_model

// ### tb/private_vlan_forward_mask_tb.sv
// Register and forwarding checks for the forwarding-mask block
`timescale 1ns/1ns
`include "pvlan_defs.svh"
module private_vlan_forward_mask_tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        hsel_i = 1'b0;
	logic        hwrite_i = 1'b0;
	logic [1:0]  htrans_i = 2'h0;
	logic [31:0] haddr_i = 32'h0;
	logic [31:0] hwdata_i = 32'h0;
	logic [31:0] rd;
	wire  [31:0] hrdata_o;
	wire         hreadyout_o, hresp_o, frm_valid_i, frm_tagged_i, fwd_valid_o;
	wire  [7:0]  frm_src_port_i, fwd_mask_o, fwd_strip_o;
	wire  [11:0] frm_vid_i, fwd_vid_o;
	int          miscompares = 0;
	int          samples_checked = 0;
	always #10 clk_i = ~clk_i;
	private_vlan_forward_mask uut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
		.hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .frm_valid_i(frm_valid_i),
		.frm_src_port_i(frm_src_port_i), .frm_tagged_i(frm_tagged_i),
		.frm_vid_i(frm_vid_i), .fwd_valid_o(fwd_valid_o), .fwd_mask_o(fwd_mask_o),
		.fwd_strip_o(fwd_strip_o), .fwd_vid_o(fwd_vid_o));
	frame_port_model fpm (.clk_i(clk_i), .frm_valid_o(frm_valid_i),
		.frm_src_port_o(frm_src_port_i), .frm_tagged_o(frm_tagged_i),
		.frm_vid_o(frm_vid_i), .fwd_valid_i(fwd_valid_o), .fwd_mask_i(fwd_mask_o),
		.fwd_strip_i(fwd_strip_o), .fwd_vid_i(fwd_vid_o));
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		hsel_i <= 1'b1;
		haddr_i <= {24'h0, a};
		htrans_i <= 2'h2;
		hwrite_i <= w;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
		hsel_i <= 1'b0;
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		samples_checked++;
		if (rd !== e) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, rd, e);
		end
	endtask
	// Strip set is the destinations that are untagged members of the vlan
	task automatic chk_frm(input logic [7:0] p, input logic t, input logic [11:0] v,
		input logic [7:0] em, input logic [7:0] es, input logic [11:0] ev);
		logic ok;
		logic [7:0] m, s;
		logic [11:0] vo;
		fpm.send(p, t, v, ok, m, s, vo);
		samples_checked++;
		if ({ok, m, s, vo} !== {1'b1, em, es, ev}) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, {ok, m, s, vo}, {1'b1, em, es, ev});
		end
	endtask
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk_i);
		miscompares++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		chk_reg(`REG_ISOLATE, 32'h0);
		chk_reg(`REG_AWARE, 32'h0);
		chk_reg(`REG_CTRL, 32'h1);
		chk_frm(8'h00, 1'b0, 12'h0, 8'hFE, 8'hFE, 12'h1);
		$display("Test reset done");
		xfer(1'b1, `REG_VLAN_SEL, 32'h2);
		xfer(1'b1, `REG_VLAN_MEMBER, 32'h7);
		xfer(1'b1, `REG_VLAN_UNTAG, 32'h3);
		xfer(1'b1, `REG_AWARE, 32'h4);
		for (int i = 0; i < 3; i++) begin
			xfer(1'b1, `REG_PORT_SEL, 32'(i));
			xfer(1'b1, `REG_PORT_PORT_DEFAULT_VLAN_ID, 32'h2);
		end
		chk_reg(`REG_PORT_PORT_DEFAULT_VLAN_ID, 32'h2);
		chk_frm(8'h00, 1'b0, 12'h0, 8'h06, 8'h02, 12'h2);
		chk_frm(8'h02, 1'b1, 12'h2, 8'h03, 8'h03, 12'h2);
		chk_frm(8'h03, 1'b1, 12'h2, 8'hF7, 8'hF7, 12'h1);
		$display("Test vlan done");
		xfer(1'b1, `REG_PVLAN_SEL, 32'h9);
		xfer(1'b1, `REG_CTRL, 32'h1);
		chk_reg(`REG_STATUS, 32'h1);
		chk_reg(`REG_CTRL, 32'h1);
		xfer(1'b1, `REG_PVLAN_SEL, 32'h2);
		xfer(1'b1, `REG_CTRL, 32'h1);
		chk_reg(`REG_STATUS, 32'h0);
		chk_reg(`REG_CTRL, 32'h3);
		chk_reg(`REG_PVLAN_MASK, 32'h0);
		xfer(1'b1, `REG_PVLAN_MASK, 32'h30);
		xfer(1'b1, `REG_PVLAN_SEL, 32'h1);
		xfer(1'b1, `REG_PVLAN_MASK, 32'hF7);
		chk_frm(8'h03, 1'b0, 12'h0, 8'h00, 8'h00, 12'h1);
		xfer(1'b1, `REG_PVLAN_SEL, 32'h2);
		xfer(1'b1, `REG_PVLAN_MASK, 32'h30);
		xfer(1'b1, `REG_ISOLATE, 32'h50);
		chk_frm(8'h04, 1'b0, 12'h0, 8'hA7, 8'hA7, 12'h1);
		chk_frm(8'h07, 1'b0, 12'h0, 8'h7F, 8'h7F, 12'h1);
		xfer(1'b1, `REG_PVLAN_MASK, 32'h38);
		chk_frm(8'h04, 1'b0, 12'h0, 8'hAF, 8'hAF, 12'h1);
		chk_frm(8'h06, 1'b0, 12'h0, 8'hA7, 8'hA7, 12'h1);
		xfer(1'b1, `REG_CTRL, 32'h2);
		chk_reg(`REG_CTRL, 32'h1);
		xfer(1'b1, 8'h40, 32'hFFFFFFFF);
		chk_reg(8'h40, 32'h0);
		$display("Test pvlan done");
		wrap_up();
	end
endmodule // private_vlan_forward_mask_tb
